// [pbc_ctrl.sv]
`timescale 1ns/1ps
`include "pbc_cfg.svh"
module pbc_ctrl
    import pbc_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = `PBC_DEAD_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic        mgmt_wr_i,
    input  wire logic [15:0] mgmt_wdata_i,
    input  wire logic        mgmt_rd_i,
    input  wire logic        an_speed_100_i,
    input  wire logic        an_full_duplex_i,
    input  wire logic        an_started_i,
    input  wire logic        tx_en_i,
    output logic      [15:0] mgmt_rdata_o,
    output logic             mgmt_rvalid_o,
    output logic             phy_reset_o,
    output logic             loopback_o,
    output logic             speed_100_o,
    output logic             an_enable_o,
    output logic             an_restart_o,
    output logic             power_down_o,
    output logic             isolate_o,
    output logic             full_duplex_o,
    output logic             collision_o,
    output logic             rx_dead_o
);
    logic      loop_reg;
    logic      speed_reg;
    logic      an_en_reg;
    logic      pdown_reg;
    logic      isolate_reg;
    logic      restart_reg;
    logic      duplex_reg;
    logic      coltest_reg;
    logic      speed_eff_reg;
    logic      duplex_eff_reg;
    logic      coll_reg;
    logic      dead_reg;
    logic      reset_reg;
    pbc_word_t rdata_reg;
    logic      rvalid_reg;
    logic      rst_busy;
    logic      dead_busy;
    logic      wr_ok;
    logic      soft_start;
    logic      clear;
    logic      dead_start;

    // Build the word seen by a management read
    function automatic pbc_word_t read_word(
        input logic busy,
        input logic loop,
        input logic speed,
        input logic an_en,
        input logic pdown,
        input logic iso,
        input logic restart,
        input logic duplex,
        input logic coltest
    );
        pbc_word_t w;
        w = '0;
        w[`PBC_BIT_RESET]       = busy;
        w[`PBC_BIT_LOOP]        = loop;
        w[`PBC_BIT_SPEED]       = speed;
        w[`PBC_BIT_AN_EN]       = an_en;
        w[`PBC_BIT_PDOWN]       = pdown;
        w[`PBC_BIT_ISOLATE]     = iso;
        w[`PBC_BIT_RESTART]     = restart;
        w[`PBC_BIT_DUPLEX]      = duplex;
        w[`PBC_BIT_COLTEST]     = coltest;
        w[`PBC_RSVD_MSB:0]      = `PBC_RSVD_VALUE;
        return w;
    endfunction : read_word

    // Write qualification and soft reset trigger
    assign wr_ok      = mgmt_wr_i && !rst_busy;
    assign soft_start = wr_ok && mgmt_wdata_i[`PBC_BIT_RESET];
    assign clear      = srst_i || soft_start;
    assign dead_start = wr_ok && !mgmt_wdata_i[`PBC_BIT_RESET] && mgmt_wdata_i[`PBC_BIT_LOOP]
                        && !loop_reg && speed_eff_reg;

    pbc_rst_seq u_rst_seq (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .start_i (soft_start),
        .busy_o  (rst_busy)
    );

    pbc_dead_timer #(
        .DEAD_CYCLES (DEAD_CYCLES)
    ) u_dead_timer (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .clear_i (soft_start),
        .start_i (dead_start),
        .busy_o  (dead_busy)
    );

    // Plain read/write control fields, returned to defaults by either reset
    always_ff @(posedge clock_i) begin
        if (clear) begin
            loop_reg    <= `PBC_RST_LOOP;
            speed_reg   <= `PBC_RST_SPEED;
            an_en_reg   <= `PBC_RST_AN_EN;
            pdown_reg   <= `PBC_RST_PDOWN;
            isolate_reg <= `PBC_RST_ISOLATE;
            coltest_reg <= `PBC_RST_COLTEST;
        end else if (wr_ok) begin
            loop_reg    <= mgmt_wdata_i[`PBC_BIT_LOOP];
            speed_reg   <= mgmt_wdata_i[`PBC_BIT_SPEED];
            an_en_reg   <= mgmt_wdata_i[`PBC_BIT_AN_EN];
            pdown_reg   <= mgmt_wdata_i[`PBC_BIT_PDOWN];
            isolate_reg <= mgmt_wdata_i[`PBC_BIT_ISOLATE];
            coltest_reg <= mgmt_wdata_i[`PBC_BIT_COLTEST];
        end
    end

    // Duplex is stored only while negotiation is off
    always_ff @(posedge clock_i) begin
        if (clear) begin
            duplex_reg <= `PBC_RST_DUPLEX;
        end else if (wr_ok && !an_en_reg) begin
            duplex_reg <= mgmt_wdata_i[`PBC_BIT_DUPLEX];
        end
    end

    // Restart request: a new write wins over the self-clear, a zero write is ignored
    always_ff @(posedge clock_i) begin
        if (clear) begin
            restart_reg <= `PBC_RST_RESTART;
        end else if (wr_ok && mgmt_wdata_i[`PBC_BIT_RESTART]
                     && mgmt_wdata_i[`PBC_BIT_AN_EN]) begin
            restart_reg <= 1'b1;
        end else if (an_started_i || !an_en_reg) begin
            restart_reg <= 1'b0;
        end
    end

    // Speed and duplex in force, negotiated ones while negotiation is on
    always_ff @(posedge clock_i) begin
        if (clear) begin
            speed_eff_reg  <= `PBC_RST_SPEED;
            duplex_eff_reg <= `PBC_RST_DUPLEX;
        end else begin
            speed_eff_reg  <= an_en_reg ? an_speed_100_i : speed_reg;
            duplex_eff_reg <= an_en_reg ? an_full_duplex_i : duplex_reg;
        end
    end

    // Collision test follows every transmit period
    always_ff @(posedge clock_i) begin
        if (clear) begin
            coll_reg <= 1'b0;
        end else begin
            coll_reg <= coltest_reg && tx_en_i;
        end
    end

    // Registered status of the reset sequence and the dead time
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reset_reg <= 1'b0;
            dead_reg  <= 1'b0;
        end else begin
            reset_reg <= soft_start || rst_busy;
            dead_reg  <= dead_busy;
        end
    end

    // Management read port, answered also in power down
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= mgmt_rd_i;
            if (mgmt_rd_i) begin
                rdata_reg <= read_word(reset_reg, loop_reg,
                                       an_en_reg ? an_speed_100_i : speed_reg,
                                       an_en_reg, pdown_reg, isolate_reg, restart_reg,
                                       an_en_reg ? an_full_duplex_i : duplex_reg,
                                       coltest_reg);
            end
        end
    end

    // Outputs straight from the state flops
    assign mgmt_rdata_o  = rdata_reg;
    assign mgmt_rvalid_o = rvalid_reg;
    assign phy_reset_o   = reset_reg;
    assign loopback_o    = loop_reg;
    assign speed_100_o   = speed_eff_reg;
    assign an_enable_o   = an_en_reg;
    assign an_restart_o  = restart_reg;
    assign power_down_o  = pdown_reg;
    assign isolate_o     = isolate_reg;
    assign full_duplex_o = duplex_eff_reg;
    assign collision_o   = coll_reg;
    assign rx_dead_o     = dead_reg;

    // Checks on the control word behaviour
    localparam int SRST_MAX = `PBC_SRST_CYCLES + 2;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    sequence s_soft_write;
        wr_ok && mgmt_wdata_i[`PBC_BIT_RESET];
    endsequence

    sequence s_plain_write;
        wr_ok && !mgmt_wdata_i[`PBC_BIT_RESET];
    endsequence

    property p_soft_reset_busy;
        s_soft_write |=> ##1 phy_reset_o [*8];
    endproperty
    a_soft_reset_busy: assert property (p_soft_reset_busy) else $error("soft reset not held");

    property p_soft_reset_ends;
        s_soft_write |=> ##[1:SRST_MAX] !phy_reset_o;
    endproperty
    a_soft_reset_ends: assert property (p_soft_reset_ends) else $error("soft reset stuck");

    property p_soft_reset_defaults;
        s_soft_write |=> !loopback_o && an_enable_o && !power_down_o && !isolate_o
                         && !an_restart_o;
    endproperty
    a_soft_reset_defaults: assert property (p_soft_reset_defaults) else $error("no defaults");

    property p_loop_write;
        s_plain_write |=> loopback_o == $past(mgmt_wdata_i[`PBC_BIT_LOOP]);
    endproperty
    a_loop_write: assert property (p_loop_write) else $error("loop-back not stored");

    property p_dead_time;
        dead_start |=> ##1 rx_dead_o [*8];
    endproperty
    a_dead_time: assert property (p_dead_time) else $error("dead time missing");

    property p_speed_forced;
        s_plain_write ##1 (!an_en_reg && !soft_start) |=> speed_100_o == $past(speed_reg);
    endproperty
    a_speed_forced: assert property (p_speed_forced) else $error("forced speed lost");

    property p_speed_read_an;
        an_en_reg && mgmt_rd_i |=> mgmt_rdata_o[`PBC_BIT_SPEED] == $past(an_speed_100_i);
    endproperty
    a_speed_read_an: assert property (p_speed_read_an) else $error("speed read not negotiated");

    property p_duplex_an;
        an_en_reg && !soft_start |=> full_duplex_o == $past(an_full_duplex_i);
    endproperty
    a_duplex_an: assert property (p_duplex_an) else $error("duplex not negotiated");

    property p_pdown_answer;
        power_down_o && mgmt_rd_i |=> mgmt_rvalid_o;
    endproperty
    a_pdown_answer: assert property (p_pdown_answer) else $error("no answer in power down");

    property p_restart_hold;
        an_restart_o && !an_started_i && !soft_start && an_en_reg |=> an_restart_o;
    endproperty
    a_restart_hold: assert property (p_restart_hold) else $error("restart cleared early");

    property p_restart_zero_write;
        an_restart_o && wr_ok && !mgmt_wdata_i[`PBC_BIT_RESET] && !mgmt_wdata_i[`PBC_BIT_RESTART]
        && mgmt_wdata_i[`PBC_BIT_AN_EN] && !an_started_i |=> an_restart_o;
    endproperty
    a_restart_zero_write: assert property (p_restart_zero_write) else $error("zero write cancelled");

    property p_duplex_locked;
        an_en_reg && wr_ok && !mgmt_wdata_i[`PBC_BIT_RESET] |=> duplex_reg == $past(duplex_reg);
    endproperty
    a_duplex_locked: assert property (p_duplex_locked) else $error("duplex written under negotiation");

    property p_collision;
        coltest_reg && tx_en_i && !soft_start |=> collision_o;
    endproperty
    a_collision: assert property (p_collision) else $error("collision test missing");

    property p_reserved_zero;
        mgmt_rvalid_o |-> mgmt_rdata_o[`PBC_RSVD_MSB:0] == `PBC_RSVD_VALUE;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_one_answer;
        mgmt_rd_i ##1 !mgmt_rd_i |=> !mgmt_rvalid_o;
    endproperty
    a_one_answer: assert property (p_one_answer) else $error("extra read answer");
endmodule : pbc_ctrl

// [pbc_cfg.svh]
// Contract
// - Writing one to bit 15 resets all PHY registers; bit reads one until done.
// - Bit 14 enables loop-back when set; resets to zero.
// - Loop-back set at 100Mbps may block reception for about 720ms.
// - Bit 13 selects 100Mbps when one, 10Mbps when zero; resets to one.
// - With auto-negotiation on, speed bit reads the negotiated medium type.
// - Bit 12 enables auto-negotiation, resets to one; duplex and speed report outcome.
// - Bit 11 powers down, resets to zero; management access still answered.
// - Writing one to bit 9 restarts negotiation; reads one until initiated.
// - Writing zero to restart during negotiation leaves negotiation unaffected.
// - Bit 8 full duplex, resets to one; writable only with auto-negotiation off.
// - Bit 7 set asserts collision throughout every transmit period; resets to zero.
// - Reserved bits six to zero read zero; writes to them are discarded.
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH

// Field positions of the control word
`define PBC_BIT_RESET     15
`define PBC_BIT_LOOP      14
`define PBC_BIT_SPEED     13
`define PBC_BIT_AN_EN     12
`define PBC_BIT_PDOWN     11
`define PBC_BIT_ISOLATE   10
`define PBC_BIT_RESTART   9
`define PBC_BIT_DUPLEX    8
`define PBC_BIT_COLTEST   7
`define PBC_RSVD_MSB      6

// Reset values of the writable fields
`define PBC_RST_LOOP      1'b0
`define PBC_RST_SPEED     1'b1
`define PBC_RST_AN_EN     1'b1
`define PBC_RST_PDOWN     1'b0
`define PBC_RST_ISOLATE   1'b0
`define PBC_RST_RESTART   1'b0
`define PBC_RST_DUPLEX    1'b1
`define PBC_RST_COLTEST   1'b0
`define PBC_RSVD_VALUE    7'h00

// Timing
`define PBC_CLK_HZ        25000000
`define PBC_DEAD_TIME_MS  720
`define PBC_DEAD_CYCLES   (`PBC_DEAD_TIME_MS * (`PBC_CLK_HZ / 1000))
`define PBC_SRST_TIME_NS  640
`define PBC_SRST_CYCLES   ((`PBC_SRST_TIME_NS * (`PBC_CLK_HZ / 1000000) + 999) / 1000)

`endif

// [pbc_pkg.sv]
package pbc_pkg;
    // Soft reset sequencer states
    typedef enum logic [1:0] {
        PBC_RS_IDLE = 2'b01,
        PBC_RS_RUN  = 2'b10
    } pbc_rs_e;

    typedef logic [15:0] pbc_word_t;
    typedef logic [4:0]  pbc_srst_cnt_t;
    typedef logic [24:0] pbc_dead_cnt_t;
endpackage : pbc_pkg

// [pbc_rst_seq.sv]
`timescale 1ns/1ps
`include "pbc_cfg.svh"
module pbc_rst_seq
    import pbc_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic srst_i,
    input  wire logic start_i,
    output logic      busy_o
);
    localparam pbc_srst_cnt_t LAST = pbc_srst_cnt_t'(`PBC_SRST_CYCLES - 1);

    pbc_rs_e       state_reg;
    pbc_srst_cnt_t cnt_reg;

    // Sequencer holds busy for the whole reset sequence
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg <= PBC_RS_IDLE;
        end else begin
            unique case (state_reg)
                PBC_RS_IDLE: begin
                    if (start_i) begin
                        state_reg <= PBC_RS_RUN;
                    end
                end
                PBC_RS_RUN: begin
                    if (cnt_reg == LAST) begin
                        state_reg <= PBC_RS_IDLE;
                    end
                end
                default: begin
                    state_reg <= PBC_RS_IDLE;
                end
            endcase
        end
    end

    // Cycle counter of the sequence
    always_ff @(posedge clock_i) begin
        if (srst_i || state_reg != PBC_RS_RUN) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    assign busy_o = (state_reg == PBC_RS_RUN);
endmodule : pbc_rst_seq

// [pbc_dead_timer.sv]
`timescale 1ns/1ps
module pbc_dead_timer
    import pbc_pkg::*;
#(
    parameter int unsigned DEAD_CYCLES = 18000000
) (
    input  wire logic clock_i,
    input  wire logic srst_i,
    input  wire logic clear_i,
    input  wire logic start_i,
    output logic      busy_o
);
    localparam pbc_dead_cnt_t LOAD = pbc_dead_cnt_t'(DEAD_CYCLES - 1);

    pbc_dead_cnt_t cnt_reg;
    logic          busy_reg;

    // Down counter spanning the receive dead time
    always_ff @(posedge clock_i) begin
        if (srst_i || clear_i) begin
            busy_reg <= 1'b0;
            cnt_reg  <= '0;
        end else if (start_i) begin
            busy_reg <= 1'b1;
            cnt_reg  <= LOAD;
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 25'h0000001;
            end
        end
    end

    assign busy_o = busy_reg;
endmodule : pbc_dead_timer

// [pbc_mgmt_model.sv]
`timescale 1ns/1ps
module pbc_mgmt_model
    import pbc_pkg::*;
(
    input  wire logic        clock_i,
    output logic             mgmt_wr_o,
    output logic      [15:0] mgmt_wdata_o,
    output logic             mgmt_rd_o
);
    // Idle bus at time zero
    initial begin
        mgmt_wr_o    = 1'b0;
        mgmt_wdata_o = 16'h5a5a;
        mgmt_rd_o    = 1'b0;
    end

    // One whole word per write; data line scrambled once the strobe drops
    task automatic do_wr(input logic [15:0] w);
        @(posedge clock_i);
        mgmt_wr_o    <= 1'b1;
        mgmt_wdata_o <= w;
        @(posedge clock_i);
        mgmt_wr_o    <= 1'b0;
        mgmt_wdata_o <= ~w;
    endtask : do_wr

    // One read strobe per word
    task automatic do_rd;
        @(posedge clock_i);
        mgmt_rd_o <= 1'b1;
        @(posedge clock_i);
        mgmt_rd_o <= 1'b0;
    endtask : do_rd
endmodule : pbc_mgmt_model

// [pbc_ctrl_tb.sv]
`timescale 1ns/1ps
module pbc_ctrl_tb
    import pbc_pkg::*;
;
    localparam int unsigned DEAD = 20;

    logic        clock_i = 1'b0;
    logic        srst_i;
    logic        mgmt_wr;
    logic [15:0] mgmt_wdata;
    logic        mgmt_rd;
    logic        an_speed_100_i;
    logic        an_full_duplex_i;
    logic        an_started_i;
    logic        tx_en_i;
    logic [15:0] mgmt_rdata_o;
    logic        mgmt_rvalid_o;
    logic        phy_reset_o;
    logic        loopback_o;
    logic        speed_100_o;
    logic        an_enable_o;
    logic        an_restart_o;
    logic        power_down_o;
    logic        isolate_o;
    logic        full_duplex_o;
    logic        collision_o;
    logic        rx_dead_o;
    logic [15:0] exp_q[$];
    logic [15:0] exp_w;
    logic [15:0] w;
    logic [31:0] seed = 32'h75c4adab;
    logic [5:0]  pat = 6'b011110;
    int          n;
    int          n_fail = 0;
    int          compares = 0;

    // Clock
    always #20 clock_i = ~clock_i;

    pbc_mgmt_model mdl_u (
        .clock_i      (clock_i),
        .mgmt_wr_o    (mgmt_wr),
        .mgmt_wdata_o (mgmt_wdata),
        .mgmt_rd_o    (mgmt_rd)
    );

    pbc_ctrl #(.DEAD_CYCLES(DEAD)) dut_u (
        .clock_i          (clock_i),
        .srst_i           (srst_i),
        .mgmt_wr_i        (mgmt_wr),
        .mgmt_wdata_i     (mgmt_wdata),
        .mgmt_rd_i        (mgmt_rd),
        .an_speed_100_i   (an_speed_100_i),
        .an_full_duplex_i (an_full_duplex_i),
        .an_started_i     (an_started_i),
        .tx_en_i          (tx_en_i),
        .mgmt_rdata_o     (mgmt_rdata_o),
        .mgmt_rvalid_o    (mgmt_rvalid_o),
        .phy_reset_o      (phy_reset_o),
        .loopback_o       (loopback_o),
        .speed_100_o      (speed_100_o),
        .an_enable_o      (an_enable_o),
        .an_restart_o     (an_restart_o),
        .power_down_o     (power_down_o),
        .isolate_o        (isolate_o),
        .full_duplex_o    (full_duplex_o),
        .collision_o      (collision_o),
        .rx_dead_o        (rx_dead_o)
    );

    // Pseudo-random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    // Compare a read word
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk_word

    // Compare an output level
    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %b seen %b", nm, e, g);
            n_fail++;
        end
    endtask : chk_bit

    // Counts and verdict
    task automatic results;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // Let k edges pass, then look at settled outputs
    task automatic settle(input int k);
        repeat (k) @(posedge clock_i);
        @(negedge clock_i);
    endtask : settle

    // Note the expected word, then issue the read
    task automatic rd_chk(input logic [15:0] e);
        exp_q.push_back(e);
        mdl_u.do_rd();
    endtask : rd_chk

    // Read monitor takes the oldest note on each answer, sampled once settled
    always @(negedge clock_i) begin
        if (mgmt_rvalid_o === 1'b1) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
            chk_word("mgmt_rdata", exp_w, mgmt_rdata_o);
        end
    end

    // Watchdog
    initial begin
        repeat (3000) @(posedge clock_i);
        n_fail++;
        results();
    end

    // Main sequence
    initial begin
        srst_i           = 1'b1;
        an_speed_100_i   = 1'b1;
        an_full_duplex_i = 1'b1;
        an_started_i     = 1'b0;
        tx_en_i          = 1'b0;
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        settle(1);
        chk_bit("loopback", 1'b0, loopback_o);
        chk_bit("speed_100", 1'b1, speed_100_o);
        chk_bit("an_enable", 1'b1, an_enable_o);
        chk_bit("power_down", 1'b0, power_down_o);
        chk_bit("isolate", 1'b0, isolate_o);
        chk_bit("full_duplex", 1'b1, full_duplex_o);
        chk_bit("collision", 1'b0, collision_o);
        rd_chk(16'h3100);
        // Negotiated outcome overrides written speed and duplex
        @(posedge clock_i);
        an_speed_100_i   <= 1'b0;
        an_full_duplex_i <= 1'b0;
        seed = xs(seed);
        mdl_u.do_wr(16'h3100 | {9'h000, seed[6:0]});
        settle(1);
        chk_bit("speed_100", 1'b0, speed_100_o);
        chk_bit("full_duplex", 1'b0, full_duplex_o);
        rd_chk(16'h1000);
        // Restart holds until the engine starts; writing zero leaves it
        mdl_u.do_wr(16'h1200);
        settle(1);
        chk_bit("an_restart", 1'b1, an_restart_o);
        rd_chk(16'h1200);
        mdl_u.do_wr(16'h1000);
        settle(1);
        chk_bit("an_restart", 1'b1, an_restart_o);
        @(posedge clock_i);
        an_started_i <= 1'b1;
        @(posedge clock_i);
        an_started_i <= 1'b0;
        settle(1);
        chk_bit("an_restart", 1'b0, an_restart_o);
        rd_chk(16'h1000);
        // Random words with negotiation off; turn it off first so bit 8 lands
        mdl_u.do_wr(16'h0000);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            w = seed[15:0] & 16'h69ff;
            an_speed_100_i   <= seed[16];
            an_full_duplex_i <= seed[17];
            mdl_u.do_wr(w);
            settle(1);
            chk_bit("speed_100", w[13], speed_100_o);
            chk_bit("full_duplex", w[8], full_duplex_o);
            chk_bit("power_down", w[11], power_down_o);
            chk_bit("an_restart", 1'b0, an_restart_o);
            rd_chk(w & 16'h6d80);
        end
        // Loop-back at 100M opens the receive dead time
        mdl_u.do_wr(16'h2000);
        repeat (30) @(posedge clock_i);
        mdl_u.do_wr(16'h6000);
        n = 0;
        repeat (40) begin
            @(negedge clock_i);
            if (rx_dead_o === 1'b1) n++;
        end
        chk_bit("loopback", 1'b1, loopback_o);
        chk_bit("rx_dead_len", 1'b1, n >= DEAD && n <= DEAD + 2);
        // Powered down still answers; collision follows transmit
        mdl_u.do_wr(16'h2880);
        settle(1);
        chk_bit("isolate", 1'b0, isolate_o);
        rd_chk(16'h2880);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock_i);
            tx_en_i <= pat[i];
            @(negedge clock_i);
            chk_bit("collision", (i > 0) ? pat[i-1] : 1'b0, collision_o);
        end
        // Soft reset: defaults, bit reads one, writes dropped meanwhile
        @(posedge clock_i);
        an_speed_100_i   <= 1'b1;
        an_full_duplex_i <= 1'b1;
        seed = xs(seed);
        mdl_u.do_wr(16'h8000 | seed[15:0]);
        fork
            begin
                n = 0;
                repeat (40) begin
                    @(negedge clock_i);
                    if (phy_reset_o === 1'b1) n++;
                end
            end
            begin
                settle(2);
                rd_chk(16'hb100);
                mdl_u.do_wr(16'h4000);
            end
        join
        chk_bit("reset_len", 1'b1, n == 17);
        rd_chk(16'h3100);
        repeat (3) @(posedge clock_i);
        results();
    end
endmodule : pbc_ctrl_tb
